// *** hw/prs_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Symbol buffer, power of two depth
// ----------------------------------------
module prs_fifo #(
   parameter int WIDTH = 5,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   prs_fifo_if.buf_mp port
);
   import prs_pkg::*;

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr_q;
   logic [AW:0] rd_ptr_q;
   logic full;
   logic empty;
   logic push;
   logic pop;

   // Extra pointer bit tells full from empty
   assign empty = (wr_ptr_q == rd_ptr_q);
   assign full = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
   assign port.wr_ready = !full;
   assign port.rd_valid = !empty;
   assign port.rd_data = mem[rd_ptr_q[AW-1:0]];
   assign push = port.wr_valid && !full;
   assign pop = port.rd_ready && !empty;

   // Storage, no reset needed
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_q[AW-1:0]] <= port.wr_data;
      end
   end

   // Write pointer
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_ptr_q <= '0;
      end else if (push) begin
         wr_ptr_q <= wr_ptr_q + 1'b1;
      end
   end

   // Read pointer
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rd_ptr_q <= '0;
      end else if (pop) begin
         rd_ptr_q <= rd_ptr_q + 1'b1;
      end
   end

endmodule

`default_nettype wire

// *** hw/prs_fifo_if.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Valid/ready carrier around the symbol buffer
// ----------------------------------------
interface prs_fifo_if #(parameter int WIDTH = 5);
   logic wr_valid;
   logic wr_ready;
   logic [WIDTH-1:0] wr_data;
   logic rd_valid;
   logic rd_ready;
   logic [WIDTH-1:0] rd_data;

   modport buf_mp (input wr_valid, input wr_data, input rd_ready,
                   output wr_ready, output rd_valid, output rd_data);
   modport user_mp (output wr_valid, output wr_data, output rd_ready,
                    input wr_ready, input rd_valid, input rd_data);
endinterface

`default_nettype wire

// *** hw/prs_pkg.sv ***
// ----------------------------------------
// Shared types of the receive status port
// ----------------------------------------
package prs_pkg;

   typedef logic [3:0] prs_nib_t;

   typedef struct packed {
      logic err;
      prs_nib_t sym;
   } prs_word_s;

   // Gray coded along idle, send, last, gap
   typedef enum logic [1:0] {
      PRS_IDLE = 2'h0,
      PRS_SEND = 2'h1,
      PRS_LAST = 2'h3,
      PRS_GAP = 2'h2
   } prs_state_e;

endpackage

// *** hw/prs_regs.svh ***
`ifndef PRS_REGS_SVH
`define PRS_REGS_SVH

// ----------------------------------------
// Strap defaults and reset values
// ----------------------------------------
`define PRS_ADDR_RST 5'h01
`define PRS_RXD_STRAP_DFLT 4'h0
`define PRS_COL_STRAP_DFLT 1'b1
`define PRS_XOVER_STRAP_RST 1'b1
`define PRS_LEDCFG_STRAP_RST 1'b1

// ----------------------------------------
// Data word layout and buffering
// ----------------------------------------
`define PRS_WORD_W 5
`define PRS_W_ERR 4
`define PRS_FIFO_DEPTH 8
`define PRS_CORRUPT_NIB 4'h5
`define PRS_RMII_MASK 4'h3
`define PRS_SYNC_W 17

`endif

// *** hw/prs_rx_port.sv ***
// Summary of operation
// - Valid follows data, not carrier sense
// - Error flag marks bad symbol, link timed
// - Errored symbols delivered as corrupt data
// - Data on link clock, valid-qualified, nibble/dibit
// - Address straps: data pins low, collision high
// - Unstrapped address reads as one
// - MII carrier sense while medium busy
// - RMII merges carrier and valid
// - Full duplex MII collision stays low
// - Half duplex collision when both busy
// - RMII leaves collision unused
// - Line pair signalling follows speed
// - Crossover may receive on transmit pair
// - Crossover may transmit on receive pair
// - MII receive clock regenerated from stream
// - RMII timed by shared reference clock
`timescale 1ns/1ps
`default_nettype none
`include "prs_regs.svh"

module prs_rx_port (
   input wire logic MCLK,
   input wire logic RESETN,
   // Configuration from same-clock logic
   input wire logic RMII_MODE,
   input wire logic FULL_DUPLEX,
   input wire logic SPEED_100,
   input wire logic MDIX_ACTIVE,
   input wire logic TX_ACTIVE,
   input wire logic TX_LINE_BIT,
   // Decoder side, recovered or reference clock
   input wire logic LINK_CLK,
   input wire logic LINE_SYM_VALID,
   input wire logic LINE_SYM_ERR,
   input wire prs_pkg::prs_nib_t LINE_SYM,
   input wire logic LINE_ACTIVE,
   output logic LINE_READY,
   // Shared receive and status pins
   output logic RX_CLK_O,
   output logic RECEIVE_DATA_VALID,
   input wire prs_pkg::prs_nib_t RXD_I,
   output prs_pkg::prs_nib_t RXD_O,
   output logic RXD_OE,
   input wire logic RECEIVE_ERROR_FLAG_I,
   output logic RECEIVE_ERROR_FLAG_O,
   output logic RECEIVE_ERROR_FLAG_OE,
   input wire logic CARRIER_SENSE_I,
   output logic CARRIER_SENSE_O,
   output logic CARRIER_SENSE_OE,
   input wire logic COL_I,
   output logic COL_O,
   output logic COL_OE,
   // Line pairs
   input wire logic TX_PAIR_I,
   output logic TX_PAIR_O,
   output logic TX_PAIR_OE,
   input wire logic RX_PAIR_I,
   output logic RX_PAIR_O,
   output logic RX_PAIR_OE,
   output logic LINE_RX_BIT,
   output logic PAIR_MODE_100,
   // Captured straps
   output logic [4:0] PHY_ADDRESS_STRAP,
   output logic CROSSOVER_ENABLE_STRAP,
   output logic INDICATOR_CONFIG_STRAP
);
   import prs_pkg::*;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // RMII carries a dibit, upper lines stay low
   function automatic prs_nib_t lane_mask(input logic rmii, input prs_nib_t nib);
      lane_mask = rmii ? (nib & `PRS_RMII_MASK) : nib;
   endfunction

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic [`PRS_SYNC_W-1:0] sync_in;
   logic [`PRS_SYNC_W-1:0] sync_s1;
   logic [`PRS_SYNC_W-1:0] sync_s2;

   assign sync_in = {LINK_CLK, LINE_SYM_VALID, LINE_SYM_ERR, LINE_SYM, LINE_ACTIVE,
                     RXD_I, COL_I, RECEIVE_ERROR_FLAG_I, CARRIER_SENSE_I,
                     TX_PAIR_I, RX_PAIR_I};

   // Two flops per bit; data changes away from the link rising edge,
   // so all bits settle together before that edge is seen here
   genvar gi;
   generate
      for (gi = 0; gi < `PRS_SYNC_W; gi++) begin : g_sync
         always_ff @(posedge MCLK) begin
            sync_s1[gi] <= sync_in[gi];
            sync_s2[gi] <= sync_s1[gi];
         end
      end
   endgenerate

   logic link_clk_s;
   logic sym_valid_s;
   logic sym_err_s;
   prs_nib_t sym_s;
   logic active_s;
   prs_nib_t rxd_pin_s;
   logic col_pin_s;
   logic rxer_pin_s;
   logic crs_pin_s;
   logic tx_pair_s;
   logic rx_pair_s;

   assign {link_clk_s, sym_valid_s, sym_err_s, sym_s, active_s,
           rxd_pin_s, col_pin_s, rxer_pin_s, crs_pin_s,
           tx_pair_s, rx_pair_s} = sync_s2;

   // ----------------------------------------
   // Link clock edges
   // ----------------------------------------
   logic link_clk_q;
   logic rise_evt;
   logic fall_evt;

   // Third stage only for edge finding
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         link_clk_q <= 1'b0;
      end else begin
         link_clk_q <= link_clk_s;
      end
   end

   assign rise_evt = link_clk_s && !link_clk_q;
   assign fall_evt = !link_clk_s && link_clk_q;

   // ----------------------------------------
   // Strap capture
   // ----------------------------------------
   logic [4:0] addr_q;
   logic xover_q;
   logic ledcfg_q;
   logic drive_q;

   // Pins are inputs while reset is low; the last sample before
   // release is kept. Hold reset four cycles so the syncs fill.
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         addr_q <= {rxd_pin_s, col_pin_s};
         xover_q <= rxer_pin_s;
         ledcfg_q <= crs_pin_s;
      end
   end

   // Drivers come on one cycle after release, never during reset
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         drive_q <= 1'b0;
      end else begin
         drive_q <= 1'b1;
      end
   end

   // With pins left open the pulls give rxd low and col high
   assign PHY_ADDRESS_STRAP = addr_q;
   assign CROSSOVER_ENABLE_STRAP = xover_q;
   assign INDICATOR_CONFIG_STRAP = ledcfg_q;
   assign RXD_OE = drive_q;
   assign RECEIVE_ERROR_FLAG_OE = drive_q;
   assign CARRIER_SENSE_OE = drive_q;
   assign COL_OE = drive_q;

   // ----------------------------------------
   // Symbol buffer
   // ----------------------------------------
   prs_fifo_if #(.WIDTH(`PRS_WORD_W)) sym_if ();
   prs_word_s rd_word;

   // Taken on the link rising edge, as the decoder presents it
   assign sym_if.wr_valid = rise_evt && sym_valid_s;
   assign sym_if.wr_data = {sym_err_s, sym_s};
   assign LINE_READY = sym_if.wr_ready;
   assign rd_word = sym_if.rd_data;

   prs_fifo #(.WIDTH(`PRS_WORD_W), .DEPTH(`PRS_FIFO_DEPTH)) u_fifo (
      .clk(MCLK),
      .rst_n(RESETN),
      .port(sym_if.buf_mp)
   );

   // ----------------------------------------
   // Output sequencer
   // ----------------------------------------
   prs_state_e state_q;
   prs_state_e state_d;
   logic pop;

   // Pops only on the falling link edge, so the MAC sees
   // half a link period of setup before its rising edge
   assign pop = fall_evt && (state_q == PRS_IDLE || state_q == PRS_SEND);
   assign sym_if.rd_ready = pop;

   always_comb begin
      state_d = state_q;
      case (state_q)
         PRS_IDLE: begin
            if (fall_evt && sym_if.rd_valid) begin
               state_d = PRS_SEND;
            end
         end
         PRS_SEND: begin
            if (fall_evt && !sym_if.rd_valid) begin
               state_d = PRS_LAST;
            end
         end
         PRS_LAST: begin
            state_d = PRS_GAP;
         end
         PRS_GAP: begin
            state_d = PRS_IDLE;
         end
         default: begin
            state_d = PRS_IDLE;
         end
      endcase
   end

   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         state_q <= PRS_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------
   // Receive data, valid and error
   // ----------------------------------------
   logic dv_q;
   logic rxer_q;
   prs_nib_t rxd_q;
   logic pop_ok;

   assign pop_ok = pop && sym_if.rd_valid;

   // Valid tracks buffered symbols only, carrier plays no part
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         dv_q <= 1'b0;
      end else if (fall_evt) begin
         dv_q <= pop_ok;
      end
   end

   // Error goes out with its symbol on the same link edge
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         rxer_q <= 1'b0;
      end else if (fall_evt) begin
         rxer_q <= pop_ok && rd_word.err;
      end
   end

   // Bad symbols replaced so a MAC ignoring the flag still drops them
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         rxd_q <= '0;
      end else if (fall_evt) begin
         if (!pop_ok) begin
            rxd_q <= '0;
         end else if (rd_word.err) begin
            rxd_q <= lane_mask(RMII_MODE, `PRS_CORRUPT_NIB);
         end else begin
            rxd_q <= lane_mask(RMII_MODE, rd_word.sym);
         end
      end
   end

   assign RECEIVE_DATA_VALID = dv_q;
   assign RECEIVE_ERROR_FLAG_O = rxer_q;
   assign RXD_O = rxd_q;

   // ----------------------------------------
   // Receive clock
   // ----------------------------------------
   logic rx_clk_q;

   // MII regenerates the stream clock; RMII uses the shared reference
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         rx_clk_q <= 1'b0;
      end else begin
         rx_clk_q <= !RMII_MODE && link_clk_s;
      end
   end

   assign RX_CLK_O = rx_clk_q;

   // ----------------------------------------
   // Carrier sense and collision
   // ----------------------------------------
   logic crs_q;
   logic col_q;

   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         crs_q <= 1'b0;
      end else if (RMII_MODE) begin
         crs_q <= active_s || dv_q;
      end else begin
         crs_q <= active_s;
      end
   end

   // Collision is a level, only half duplex MII reports it
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         col_q <= 1'b0;
      end else if (RMII_MODE || FULL_DUPLEX) begin
         col_q <= 1'b0;
      end else begin
         col_q <= active_s && TX_ACTIVE;
      end
   end

   assign CARRIER_SENSE_O = crs_q;
   assign COL_O = col_q;

   // ----------------------------------------
   // Line pair routing
   // ----------------------------------------
   logic swap_q;
   logic mode100_q;
   logic line_rx_q;
   logic tx_bit_q;

   // Swap allowed only when strapped in; registered so pairs flip together
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         swap_q <= 1'b0;
         mode100_q <= 1'b0;
         tx_bit_q <= 1'b0;
      end else begin
         swap_q <= xover_q && MDIX_ACTIVE;
         mode100_q <= SPEED_100;
         tx_bit_q <= TX_LINE_BIT;
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         line_rx_q <= 1'b0;
      end else begin
         line_rx_q <= swap_q ? tx_pair_s : rx_pair_s;
      end
   end

   assign TX_PAIR_O = swap_q ? 1'b0 : tx_bit_q;
   assign TX_PAIR_OE = !swap_q;
   assign RX_PAIR_O = swap_q ? tx_bit_q : 1'b0;
   assign RX_PAIR_OE = swap_q;
   assign LINE_RX_BIT = line_rx_q;
   assign PAIR_MODE_100 = mode100_q;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RESETN || !drive_q); // Release edge skipped, outputs still hold reset values

   sequence s_send_empty;
      state_q == PRS_SEND && fall_evt && !sym_if.rd_valid;
   endsequence

   sequence s_gap_done;
      state_q == PRS_LAST ##1 state_q == PRS_GAP ##1 state_q == PRS_IDLE;
   endsequence

   a_valid_on_pop: assert property (pop_ok |=> dv_q)
      else $error("valid missing after symbol pop");

   a_frame_end: assert property (s_send_empty |=> !dv_q ##0 s_gap_done)
      else $error("frame end sequence broken");

   a_error_in_frame: assert property (rxer_q |-> dv_q)
      else $error("error flag outside valid");

   a_error_corrupts: assert property (rxer_q |-> rxd_q == lane_mask(RMII_MODE, `PRS_CORRUPT_NIB))
      else $error("errored symbol not corrupted");

   a_idle_data_low: assert property (!dv_q |-> rxd_q == '0)
      else $error("data lines busy without valid");

   a_data_on_fall: assert property (!fall_evt |=> $stable(rxd_q))
      else $error("data moved off the link edge");

   a_strap_frozen: assert property ($past(RESETN) |-> $stable(addr_q))
      else $error("strap changed after reset");

   a_no_drive_reset: assert property (disable iff (1'b0) !RESETN |=> !drive_q)
      else $error("pins driven during reset");

   a_crs_mii: assert property (!RMII_MODE |=> crs_q == $past(active_s))
      else $error("carrier sense mismatch");

   a_carrier_and_valid_combined_rmii: assert property (RMII_MODE && dv_q |=> crs_q)
      else $error("combined carrier missing valid");

   a_col_full: assert property (FULL_DUPLEX |=> !col_q)
      else $error("collision in full duplex");

   a_col_half: assert property (!RMII_MODE && !FULL_DUPLEX && active_s && TX_ACTIVE |=> col_q)
      else $error("collision not reported");

   a_col_rmii: assert property (RMII_MODE |=> !col_q)
      else $error("collision used in RMII");

   a_rxclk_rmii: assert property (RMII_MODE |=> !rx_clk_q)
      else $error("receive clock toggles in RMII");

   a_pair_swap: assert property (xover_q && MDIX_ACTIVE |=> RX_PAIR_OE && !TX_PAIR_OE)
      else $error("pairs not swapped");

   a_pair_speed: assert property (SPEED_100 |=> PAIR_MODE_100)
      else $error("pair mode ignores speed");

endmodule

`default_nettype wire

// *** tb/prs_mac_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Far side: pin pulls, strap resistors and line partner
// ----------------------------------------
module prs_mac_model (
   input wire logic strap_en,
   input wire logic [6:0] strap_val,
   input wire logic [3:0] rxd_o,
   input wire logic rxd_oe,
   input wire logic er_o,
   input wire logic er_oe,
   input wire logic crs_o,
   input wire logic crs_oe,
   input wire logic col_o,
   input wire logic col_oe,
   input wire logic txp_o,
   input wire logic txp_oe,
   input wire logic rxp_o,
   input wire logic rxp_oe,
   input wire logic far_bit,
   output logic [3:0] rxd_i,
   output logic er_i,
   output logic crs_i,
   output logic col_i,
   output logic txp_i,
   output logic rxp_i
);
   // Released pins fall to their pulls unless a strap resistor is fitted
   assign rxd_i = rxd_oe ? rxd_o : (strap_en ? strap_val[4:1] : 4'h0);
   assign col_i = col_oe ? col_o : (strap_en ? strap_val[0] : 1'b1);
   // Error pin doubles as the crossover strap and is pulled high when left open
   assign er_i = er_oe ? er_o : (strap_en ? strap_val[5] : 1'b1);
   assign crs_i = crs_oe ? crs_o : (strap_en ? strap_val[6] : 1'b1);
   // Far end drives whichever pair the device leaves free
   assign txp_i = txp_oe ? txp_o : far_bit;
   assign rxp_i = rxp_oe ? rxp_o : far_bit;
endmodule

`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "prs_regs.svh"

module testbench;
   import prs_pkg::*;
   logic mclk, resetn, rmii_mode, full_duplex, speed_100, mdix_active, tx_active, tx_line_bit;
   logic link_clk, line_sym_valid, line_sym_err, line_active, far_bit, strap_en, clk_seen;
   prs_nib_t line_sym, rxd_i, rxd_o;
   logic [6:0] strap_val;
   logic line_ready, rx_clk_o, rdv, rxd_oe, er_i, er_o, er_oe, crs_i, crs_o, crs_oe, col_i, col_o, col_oe;
   logic txp_i, txp_o, txp_oe, rxp_i, rxp_o, rxp_oe, line_rx_bit, pair_mode_100, xov, ledcfg;
   logic [4:0] addr;
   logic [4:0] exp_q[$];
   int mismatches, checked, seed;
   // Mode rmii, full duplex, rx busy, tx busy; then carrier and collision
   localparam logic [5:0] STAT [6] = '{6'b0011_11, 6'b0010_10, 6'b0001_00,
                                       6'b0111_10, 6'b1011_10, 6'b1101_00};

   prs_rx_port prs_rx_port_i (.MCLK(mclk), .RESETN(resetn), .RMII_MODE(rmii_mode),
      .FULL_DUPLEX(full_duplex), .SPEED_100(speed_100), .MDIX_ACTIVE(mdix_active),
      .TX_ACTIVE(tx_active), .TX_LINE_BIT(tx_line_bit), .LINK_CLK(link_clk),
      .LINE_SYM_VALID(line_sym_valid), .LINE_SYM_ERR(line_sym_err), .LINE_SYM(line_sym),
      .LINE_ACTIVE(line_active), .LINE_READY(line_ready), .RX_CLK_O(rx_clk_o),
      .RECEIVE_DATA_VALID(rdv), .RXD_I(rxd_i), .RXD_O(rxd_o), .RXD_OE(rxd_oe),
      .RECEIVE_ERROR_FLAG_I(er_i), .RECEIVE_ERROR_FLAG_O(er_o), .RECEIVE_ERROR_FLAG_OE(er_oe),
      .CARRIER_SENSE_I(crs_i), .CARRIER_SENSE_O(crs_o), .CARRIER_SENSE_OE(crs_oe),
      .COL_I(col_i), .COL_O(col_o), .COL_OE(col_oe), .TX_PAIR_I(txp_i), .TX_PAIR_O(txp_o),
      .TX_PAIR_OE(txp_oe), .RX_PAIR_I(rxp_i), .RX_PAIR_O(rxp_o), .RX_PAIR_OE(rxp_oe),
      .LINE_RX_BIT(line_rx_bit), .PAIR_MODE_100(pair_mode_100), .PHY_ADDRESS_STRAP(addr),
      .CROSSOVER_ENABLE_STRAP(xov), .INDICATOR_CONFIG_STRAP(ledcfg));

   prs_mac_model prs_mac_model_i (.strap_en(strap_en), .strap_val(strap_val), .rxd_o(rxd_o),
      .rxd_oe(rxd_oe), .er_o(er_o), .er_oe(er_oe), .crs_o(crs_o), .crs_oe(crs_oe), .col_o(col_o),
      .col_oe(col_oe), .txp_o(txp_o), .txp_oe(txp_oe), .rxp_o(rxp_o), .rxp_oe(rxp_oe),
      .far_bit(far_bit), .rxd_i(rxd_i), .er_i(er_i), .crs_i(crs_i), .col_i(col_i),
      .txp_i(txp_i), .rxp_i(rxp_i));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input string what, input logic [4:0] exp, input logic [4:0] got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Straps must sit on the pins for the whole reset, released with reset, one cycle before drivers take over
   task automatic do_reset(input logic en, input logic [6:0] val);
      @(posedge mclk);
      resetn <= 1'b0;
      strap_en <= en;
      strap_val <= val;
      repeat (4) @(posedge mclk);
      #1 chk("oe in reset", 5'h0, {1'b0, rxd_oe, er_oe, crs_oe, col_oe});
      @(posedge mclk);
      resetn <= 1'b1;
      strap_en <= 1'b0;
      repeat (3) @(posedge mclk);
      #1 chk("address strap", val[4:0], addr);
      chk("other straps", {3'h0, val[6:5]}, {3'h0, ledcfg, xov});
      chk("oe driving", 5'h0F, {1'b0, rxd_oe, er_oe, crs_oe, col_oe});
      $display("reset test done");
   endtask

   task automatic set_status(input logic [3:0] m);
      @(posedge mclk);
      {rmii_mode, full_duplex, line_active, tx_active} <= m;
      repeat (6) @(posedge mclk);
      #1;
   endtask

   // Link clock runs only inside a frame; data changes on its falling edge
   task automatic send_frame(input int n, input logic act);
      logic [3:0] s;
      logic e;
      logic [3:0] x;
      clk_seen = 1'b0;
      @(posedge mclk);
      line_active <= act;
      for (int i = 0; i <= n; i++) begin
         s = 4'($random(seed));
         // Third word always errored so every frame exercises corruption
         e = ((3'($random(seed)) == 3'h0) || (i == 2)) && (i < n);
         line_sym_valid <= (i < n);
         line_sym <= s;
         line_sym_err <= e;
         x = e ? `PRS_CORRUPT_NIB : s;
         if (rmii_mode) x = x & `PRS_RMII_MASK;
         if (i < n) exp_q.push_back({e, x});
         repeat (4) @(posedge mclk);
         link_clk <= 1'b1;
         repeat (4) @(posedge mclk);
         link_clk <= 1'b0;
      end
      line_active <= 1'b0;
      repeat (10) @(posedge mclk);
      #1 chk("words left", 5'h0, 5'(exp_q.size()));
      chk("line ready", 5'h1, {4'h0, line_ready});
      chk("idle data", 5'h0, {er_o, rxd_o});
      chk("rx clock seen", {4'h0, !rmii_mode}, {4'h0, clk_seen});
      $display("frame test done");
   endtask

   task automatic pair_check(input logic xo);
      logic sw;
      for (int k = 0; k < 4; k++) begin
         @(posedge mclk);
         {speed_100, mdix_active} <= k[1:0];
         tx_line_bit <= 1'($random(seed));
         far_bit <= 1'($random(seed));
         repeat (6) @(posedge mclk);
         #1 sw = k[0] & xo;
         chk("pairs", {speed_100, !sw, sw, tx_line_bit, far_bit},
             {pair_mode_100, txp_oe, rxp_oe, sw ? rxp_o : txp_o, line_rx_bit});
      end
      $display("pair test done");
   endtask

   // ----------------------------------------
   // Clock, monitor, watchdog, sequence
   // ----------------------------------------
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   always @(posedge mclk) if (rx_clk_o === 1'b1) clk_seen <= 1'b1;

   // Outputs settle within five edges of a link fall and stand until the next
   initial begin
      forever begin
         @(negedge link_clk);
         repeat (6) @(posedge mclk);
         #1;
         if (rdv === 1'b1) begin
            if (exp_q.size() == 0) begin
               mismatches++;
               $display("[FAIL] rx word expected none seen %h", {er_o, rxd_o});
            end else begin
               chk("rx word", exp_q.pop_front(), {er_o, rxd_o});
            end
            if (rmii_mode) chk("combined carrier", 5'h1, {4'h0, crs_o});
         end
      end
   end

   // Whole run is about 410 cycles; this leaves ample margin
   initial begin
      #400000;
      mismatches++;
      $display("[FAIL] run expected end seen hang");
      wrap_up();
   end

   initial begin
      seed = 7;
      {resetn, rmii_mode, full_duplex, speed_100, mdix_active, tx_active, tx_line_bit} = 7'h0;
      {link_clk, line_sym_valid, line_sym_err, line_active, far_bit, strap_en} = 6'h0;
      line_sym = 4'h0;
      strap_val = 7'h0;
      clk_seen = 1'b0;
      do_reset(1'b0, 7'h61);
      foreach (STAT[i]) begin
         set_status(STAT[i][5:2]);
         chk("carrier/collision", {3'h0, STAT[i][1:0]}, {3'h0, crs_o, col_o});
      end
      $display("status test done");
      set_status(4'h4);
      send_frame(12, 1'b1);
      send_frame(6, 1'b0);
      set_status(4'hC);
      send_frame(10, 1'b0);
      pair_check(1'b1);
      do_reset(1'b1, 7'h1A);
      pair_check(1'b0);
      wrap_up();
   end
endmodule

`default_nettype wire
